/* rtl/pmv_pkg.sv */
// pmv_pkg: constants, slot states and pin/core bundles for the program memory port.
// assumes one 100 MHz clock; all pins arrive asynchronously and are synchronised in the top.
package pmv_pkg;

  localparam int unsigned CLK_NS      = 10;
  localparam int unsigned PULSE_MS    = 50;
  localparam int unsigned PULSE_CLKS  = PULSE_MS * 1_000_000 / CLK_NS;
  localparam int unsigned SLOT_CLKS   = 4;
  localparam int unsigned MEM_WORDS   = 1024;
  localparam int unsigned MEM_AW      = 10;
  localparam int unsigned PC_W        = 12;
  localparam int unsigned CNT_W       = 23;
  localparam int unsigned DIV_W       = 2;
  localparam int unsigned PIN_SYNC_W  = 17;

  localparam logic [DIV_W-1:0]  DIV_LAST = DIV_W'(SLOT_CLKS - 1);
  localparam logic [DIV_W-1:0]  DIV_ZERO = 2'h0;
  localparam logic [7:0]        BYTE_ZERO = 8'h00;
  localparam logic [3:0]        NIB_ZERO  = 4'h0;
  localparam logic [PC_W-1:0]   PC_ZERO   = 12'h000;
  localparam logic [PC_W-1:0]   PC_INT_TOP = 12'h3ff;
  localparam logic [MEM_AW-1:0] ADDR_ZERO = 10'h000;
  localparam logic [CNT_W-1:0]  CNT_ZERO  = 23'h00_0000;
  localparam logic [CNT_W-1:0]  CNT_ONE   = 23'h00_0001;

  // machine cycle slots: strobe high in s0, fetch strobe low in s2
  typedef enum logic [2:0] {
    PMV_S0 = 3'b000,
    PMV_S1 = 3'b001,
    PMV_S2 = 3'b010,
    PMV_S3 = 3'b011,
    PMV_S4 = 3'b100
  } pmv_slot_e;

  typedef struct packed {
    logic       chip_reset_n;
    logic       mode_select;
    logic       external_fetch_select;
    logic       efs_high_voltage;
    logic       programming_supply;
    logic       program_pulse_input;
    logic       step_request_n;
    logic [7:0] bus_in;
    logic [1:0] upper_in;
  } pmv_pin_in_s;

  typedef struct packed {
    logic [7:0] bus_out;
    logic       bus_oe;
    logic [3:0] upper_port_address_lines;
    logic       upper_oe;
    logic       ale;
    logic       program_fetch_strobe_n;
  } pmv_pin_out_s;

  typedef struct packed {
    logic            fetch;
    logic            insn_start;
    logic [PC_W-1:0] pc;
    logic [7:0]      io_bus;
    logic            io_bus_oe;
    logic [3:0]      io_upper;
    logic            io_upper_oe;
  } pmv_core_req_s;

  typedef struct packed {
    logic       cycle_pulse;
    logic [7:0] instr;
    logic       instr_valid;
    logic       hold;
    logic       halted;
  } pmv_core_rsp_s;

endpackage

/* rtl/pmv_sync.sv */
// pmv_sync: two-flop synchroniser for a bundle of asynchronous pin levels.
// assumes inputs change slowly against clk; first stage feeds only the second.
`timescale 1ns/1ps
module pmv_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst_b,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  logic [W-1:0] meta_q;

  // two stages, cleared by synchronous reset
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      meta_q   <= '0;
      sync_out <= '0;
    end else begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule // pmv_sync

/* rtl/pmv_port.sv */
// pmv_port: program/verify port, external fetch sequencing and single step of program memory.
// assumes pins are asynchronous, core logic sits on clk and follows cycle_pulse handshakes.
`timescale 1ns/1ps
module pmv_port #(
  parameter int unsigned PULSE_MIN_CLKS = pmv_pkg::PULSE_CLKS
) (
  input  wire logic           clk,
  input  wire logic           rst_b,
  input  wire pmv_pkg::pmv_pin_in_s  pin_in,
  output pmv_pkg::pmv_pin_out_s      pin_out,
  input  wire pmv_pkg::pmv_core_req_s core_req,
  output pmv_pkg::pmv_core_rsp_s     core_rsp
);
  import pmv_pkg::*;

  localparam logic [CNT_W-1:0] PULSE_MIN = CNT_W'(PULSE_MIN_CLKS);

  typedef struct packed {
    logic [DIV_W-1:0]  div;
    pmv_slot_e         slot;
    logic              halted;
    logic              ext;
    logic              insn_start;
    logic [PC_W-1:0]   pc;
    logic              rst_prev;
    logic              pulse_prev;
    logic [CNT_W-1:0]  pulse_cnt;
    logic [7:0]        wdata;
    logic [MEM_AW-1:0] addr;
    logic              mem_we;
    pmv_pin_out_s      po;
    pmv_core_rsp_s     cr;
  } pmv_state_s;

  localparam pmv_state_s RESET_STATE = '{
    div: DIV_ZERO, slot: PMV_S0, halted: 1'b0, ext: 1'b0, insn_start: 1'b0,
    pc: PC_ZERO, rst_prev: 1'b0, pulse_prev: 1'b0, pulse_cnt: CNT_ZERO,
    wdata: BYTE_ZERO, addr: ADDR_ZERO, mem_we: 1'b0,
    po: '{bus_out: BYTE_ZERO, bus_oe: 1'b0, upper_port_address_lines: NIB_ZERO,
          upper_oe: 1'b0, ale: 1'b0, program_fetch_strobe_n: 1'b1},
    cr: '{cycle_pulse: 1'b0, instr: BYTE_ZERO, instr_valid: 1'b0, hold: 1'b1,
          halted: 1'b0}
  };

  pmv_state_s   q;
  pmv_state_s   d;
  pmv_pin_in_s  pin;
  logic [7:0]   mem [MEM_WORDS];
  logic [MEM_WORDS-1:0] written_q;
  logic [MEM_AW-1:0]    rd_addr;
  logic [7:0]   rd_data;

  // fetch goes outside when forced or when the pc leaves the internal array
  function automatic logic fetch_is_ext(input logic efs, input logic [PC_W-1:0] pc);
    fetch_is_ext = efs || (pc > PC_INT_TOP);
  endfunction

  pmv_sync #(.W(PIN_SYNC_W)) u_sync (
    .clk      (clk),
    .rst_b    (rst_b),
    .async_in (pin_in),
    .sync_out (pin)
  );

  // array read: never-programmed words read as zero
  assign rd_addr = pin.efs_high_voltage ? q.addr : q.pc[MEM_AW-1:0];
  assign rd_data = written_q[rd_addr] ? mem[rd_addr] : BYTE_ZERO;

  // next-state logic for program/verify mode and the run-time machine cycle
  always_comb begin
    d                = q;
    d.cr.cycle_pulse = 1'b0;
    d.cr.instr_valid = 1'b0;
    d.mem_we         = 1'b0;
    d.rst_prev       = pin.chip_reset_n;
    d.pulse_prev     = pin.program_pulse_input;
    d.div            = (q.div == DIV_LAST) ? DIV_ZERO : DIV_W'(q.div + 1'b1);

    // strobe clock keeps running in every mode except a single-step halt and processor reset
    if (q.div == DIV_LAST && !q.halted) begin
      d.po.ale = (q.slot == PMV_S4);
    end

    if (pin.efs_high_voltage) begin
      // program/verify mode: core held, port driven only by the word access
      d.cr.hold                  = 1'b1;
      d.cr.halted                = 1'b0;
      d.halted                   = 1'b0;
      d.po.program_fetch_strobe_n = 1'b1;
      d.po.upper_oe              = 1'b0;
      if (q.div == DIV_LAST) begin
        d.slot = (q.slot == PMV_S4) ? PMV_S0 : pmv_slot_e'(q.slot + 3'b001);
      end
      // address taken on the reset rising edge
      if (!q.rst_prev && pin.chip_reset_n) begin
        d.addr = {pin.upper_in, pin.bus_in};
      end
      if (!pin.chip_reset_n) begin
        d.po.bus_oe = 1'b0;
      end else if (pin.mode_select) begin
        d.po.bus_oe  = 1'b1;
        d.po.bus_out = rd_data;
      end else begin
        d.po.bus_oe = 1'b0;
      end
      // pulse width check while armed for programming
      if (pin.chip_reset_n && !pin.mode_select && pin.programming_supply
          && pin.program_pulse_input) begin
        if (!q.pulse_prev) begin
          d.wdata     = pin.bus_in;
          d.pulse_cnt = CNT_ONE;
        end else if (q.pulse_cnt != PULSE_MIN) begin
          d.pulse_cnt = CNT_W'(q.pulse_cnt + CNT_ONE);
        end
      end else begin
        d.pulse_cnt = CNT_ZERO;
      end
      // commit on the falling edge of a long enough pulse
      if (q.pulse_prev && !pin.program_pulse_input && q.pulse_cnt == PULSE_MIN
          && pin.chip_reset_n && !pin.mode_select && pin.programming_supply) begin
        d.mem_we = 1'b1;
      end
    end else if (!pin.chip_reset_n) begin
      // processor reset: bus released, sequencer parked before the strobe rises
      d.cr.hold                   = 1'b1;
      d.cr.halted                 = 1'b0;
      d.halted                    = 1'b0;
      d.slot                      = PMV_S4;
      d.div                       = DIV_ZERO;
      d.po.ale                    = 1'b0; // parked low so a halt ends cleanly
      d.pulse_cnt                 = CNT_ZERO;
      d.po.bus_oe                 = 1'b0;
      d.po.upper_oe               = 1'b0;
      d.po.program_fetch_strobe_n = 1'b1;
    end else begin
      d.cr.hold = 1'b0;
      if (q.halted) begin
        // stopped: strobe stays high until the step request goes back high
        if (pin.step_request_n) begin
          d.halted    = 1'b0;
          d.cr.halted = 1'b0;
          d.po.ale    = 1'b0;
          d.slot      = PMV_S1;
          d.div       = DIV_ZERO;
          if (!q.ext) begin
            d.po.bus_out  = core_req.io_bus;
            d.po.bus_oe   = core_req.io_bus_oe;
            d.po.upper_port_address_lines = core_req.io_upper;
            d.po.upper_oe = core_req.io_upper_oe;
          end
        end
      end else if (q.div == DIV_LAST) begin
        case (q.slot)
          PMV_S0: begin
            if (q.insn_start && !pin.step_request_n) begin
              d.halted      = 1'b1;
              d.cr.halted   = 1'b1;
              d.po.ale      = 1'b1;
              d.po.bus_out  = q.pc[7:0];
              d.po.bus_oe   = 1'b1;
              d.po.upper_port_address_lines = q.pc[PC_W-1:8];
              d.po.upper_oe = 1'b1;
            end else begin
              d.slot = PMV_S1;
            end
          end
          PMV_S1: begin
            d.slot = PMV_S2;
            if (q.ext) begin
              d.po.program_fetch_strobe_n = 1'b0;
              d.po.bus_oe                 = 1'b0;
            end else if (core_req.fetch) begin
              d.cr.instr       = rd_data;
              d.cr.instr_valid = 1'b1;
            end
          end
          PMV_S2: begin
            d.slot = PMV_S3;
            if (q.ext) begin
              d.cr.instr                  = pin.bus_in;
              d.cr.instr_valid            = 1'b1;
              d.po.program_fetch_strobe_n = 1'b1;
            end
          end
          PMV_S3: begin
            d.slot           = PMV_S4;
            d.cr.cycle_pulse = 1'b1;
            d.po.bus_out     = core_req.io_bus;
            d.po.bus_oe      = core_req.io_bus_oe;
            d.po.upper_port_address_lines = core_req.io_upper;
            d.po.upper_oe    = core_req.io_upper_oe;
          end
          PMV_S4: begin
            // strobe rises here with I/O still valid unless an external fetch puts the pc out, and the request is taken
            d.slot       = PMV_S0;
            d.pc         = core_req.pc;
            d.insn_start = core_req.insn_start;
            d.ext        = core_req.fetch
                           && fetch_is_ext(pin.external_fetch_select, core_req.pc);
            if (d.ext) begin
              d.po.bus_out  = core_req.pc[7:0];
              d.po.bus_oe   = 1'b1;
              d.po.upper_port_address_lines = core_req.pc[PC_W-1:8];
              d.po.upper_oe = 1'b1;
            end
          end
          default: begin
            d.slot = PMV_S0;
          end
        endcase
      end
    end
  end

  // single state register
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      q <= RESET_STATE;
    end else begin
      q <= d;
    end
  end

  // program array and its written-word marks
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      written_q <= '0;
    end else if (q.mem_we) begin
      written_q[q.addr] <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (q.mem_we) begin
      mem[q.addr] <= q.wdata;
    end
  end

  assign pin_out  = q.po;
  assign core_rsp = q.cr;

endmodule // pmv_port

/* tb/pmv_port_assertions.sv */
// pmv_port_chk: pin-level timing checks of the program memory port.
// assumes one clock domain; bound to every pmv_port instance.
`timescale 1ns/1ps
module pmv_port_chk import pmv_pkg::*; #(
  parameter int unsigned PULSE_MIN_CLKS = pmv_pkg::PULSE_CLKS
) (
  input wire logic                  clk,
  input wire logic                  rst_b,
  input wire pmv_pkg::pmv_pin_in_s   pin_in,
  input wire pmv_pkg::pmv_pin_out_s  pin_out,
  input wire pmv_pkg::pmv_core_req_s core_req,
  input wire pmv_pkg::pmv_core_rsp_s core_rsp
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  // fetch strobe low for four clocks, instruction taken as it rises
  sequence s_fetch_tail;
    (!pin_out.program_fetch_strobe_n)[*3] ##1
      (pin_out.program_fetch_strobe_n && core_rsp.instr_valid);
  endsequence
  // cycle start that is not held by a single step
  sequence s_run_start;
    $rose(pin_out.ale) && $past(core_req.fetch) && pin_in.external_fetch_select &&
      !pin_in.efs_high_voltage && !core_rsp.hold ##4 !core_rsp.halted;
  endsequence
  property p_ale_wide;
    $rose(pin_out.ale) |=> pin_out.ale[*3];
  endproperty
  property p_ale_gap;
    $fell(pin_out.ale) && !core_rsp.hold |-> ##16 $rose(pin_out.ale);
  endproperty
  property p_fetch_when;
    $fell(pin_out.program_fetch_strobe_n) |->
      $past(pin_out.ale, 8) && !$past(pin_out.ale, 4) && !core_rsp.hold;
  endproperty
  property p_fetch_addr;
    $fell(pin_out.program_fetch_strobe_n) |-> $past(pin_out.bus_oe, 4) &&
      $past({pin_out.upper_port_address_lines, pin_out.bus_out}, 8) == $past(core_req.pc, 9);
  endproperty
  property p_fetch_len;
    $fell(pin_out.program_fetch_strobe_n) |-> !pin_out.bus_oe ##1 s_fetch_tail;
  endproperty
  property p_ext_sel;
    s_run_start |-> ##4 $fell(pin_out.program_fetch_strobe_n);
  endproperty
  property p_halt_show;
    core_rsp.halted |-> pin_out.ale && pin_out.bus_oe && pin_out.upper_oe;
  endproperty
  property p_resume;
    $fell(core_rsp.halted) |-> !pin_out.ale;
  endproperty
  property p_pgm_quiet;
    pin_in.efs_high_voltage[*6] |-> pin_out.program_fetch_strobe_n && !pin_out.upper_oe;
  endproperty
  property p_cycle_tick;
    $rose(pin_out.ale) && !core_rsp.hold && !$past(core_rsp.hold, 8) |->
      $past(core_rsp.cycle_pulse, 4);
  endproperty
  property p_verify_gate;
    (pin_in.efs_high_voltage && !(pin_in.chip_reset_n && pin_in.mode_select))[*6]
      |-> !pin_out.bus_oe;
  endproperty
  a_ale_wide: assert property (p_ale_wide) else $error("strobe pulse short");
  a_ale_gap: assert property (p_ale_gap) else $error("strobe period wrong");
  a_fetch_when: assert property (p_fetch_when) else $error("fetch strobe misplaced");
  a_fetch_addr: assert property (p_fetch_addr) else $error("fetch address wrong");
  a_fetch_len: assert property (p_fetch_len) else $error("fetch strobe length");
  a_ext_sel: assert property (p_ext_sel) else $error("fetch not external");
  a_halt_show: assert property (p_halt_show) else $error("halt address missing");
  a_resume: assert property (p_resume) else $error("resume strobe high");
  a_pgm_quiet: assert property (p_pgm_quiet) else $error("program mode fetch");
  a_verify_gate: assert property (p_verify_gate) else $error("bus driven early");
  a_cycle_tick: assert property (p_cycle_tick) else $error("cycle pulse missing");
endmodule // pmv_port_chk

bind pmv_port pmv_port_chk #(.PULSE_MIN_CLKS(PULSE_MIN_CLKS)) chk_i (.clk(clk), .rst_b(rst_b),
  .pin_in(pin_in), .pin_out(pin_out), .core_req(core_req), .core_rsp(core_rsp));

/* tb/pmv_fixture.sv */
// pmv_fixture: external program memory and bus wire behind the port.
// assumes the host drives the bus only while host_en is high.
`timescale 1ns/1ps
module pmv_fixture (
  input  wire logic                  clk,
  input  wire pmv_pkg::pmv_pin_out_s pin_out,
  input  wire logic [7:0]            host_bus,
  input  wire logic                  host_en,
  output logic      [7:0]            bus_level
);
  import pmv_pkg::*;
  logic [11:0] addr_q;
  logic [7:0]  last_q = 8'h00; // known start so the idle pattern toggles
  // address taken from the wire as the strobe falls
  always_ff @(negedge pin_out.ale) begin
    addr_q <= {pin_out.upper_port_address_lines, pin_out.bus_out};
  end
  // wire level: device, memory answer, host, else a changing pattern
  always_comb begin
    if (pin_out.bus_oe) begin
      bus_level = pin_out.bus_out;
    end else if (!pin_out.program_fetch_strobe_n) begin
      bus_level = addr_q[7:0] ^ {addr_q[11:8], 4'h3};
    end else if (host_en) begin
      bus_level = host_bus;
    end else begin
      bus_level = ~last_q;
    end
  end
  always_ff @(posedge clk) begin
    last_q <= bus_level;
  end
endmodule // pmv_fixture

/* tb/test_pmv_port.sv */
// test_pmv_port: self-checking bench for the program memory port.
// assumes pmv_port and pmv_fixture; pulse length shortened to 20 clocks.
`timescale 1ns/1ps
module test_pmv_port;
  import pmv_pkg::*;
  localparam int unsigned PMIN = 20;
  logic          clk;
  logic          rst_b;
  logic          host_en;
  logic [7:0]    bus_level;
  pmv_pin_in_s   drv;
  pmv_pin_in_s   pin_in;
  pmv_pin_out_s  pin_out;
  pmv_core_req_s core_req;
  pmv_core_rsp_s core_rsp;
  int            miscompares;
  int            checks;
  pmv_port #(.PULSE_MIN_CLKS(PMIN)) uut (.clk(clk), .rst_b(rst_b), .pin_in(pin_in),
    .pin_out(pin_out), .core_req(core_req), .core_rsp(core_rsp));
  pmv_fixture fx (.clk(clk), .pin_out(pin_out), .host_bus(drv.bus_in), .host_en(host_en),
    .bus_level(bus_level));
  // resolved pin levels seen by the port
  always_comb begin
    pin_in = drv;
    pin_in.bus_in = bus_level;
    if (pin_out.upper_oe) begin
      pin_in.upper_in = pin_out.upper_port_address_lines[1:0];
    end
  end
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic test_done;
    if (miscompares == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic chk(input string what, input logic [11:0] exp, input logic [11:0] got);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic bound(input int n, input int lim);
    if (n >= lim) begin
      miscompares++;
      test_done();
    end
  endtask
  // one address/data/pulse/verify pass of the programming sequence
  task automatic write_word(input logic [9:0] a, input logic [7:0] d, input int len);
    drv.mode_select = 1'b0;
    drv.chip_reset_n = 1'b0;
    cyc(4);
    drv.bus_in = a[7:0];
    drv.upper_in = a[9:8];
    host_en = 1'b1;
    cyc(4);
    drv.chip_reset_n = 1'b1;
    cyc(4);
    drv.bus_in = d;
    drv.programming_supply = 1'b1;
    cyc(4);
    drv.program_pulse_input = 1'b1;
    cyc(len);
    drv.program_pulse_input = 1'b0;
    cyc(4);
    drv.programming_supply = 1'b0;
    host_en = 1'b0;
    drv.mode_select = 1'b1;
    cyc(8);
  endtask
  task automatic t_reset;
    chk("idle pins", 12'h401, {1'b0, core_rsp.hold, pin_out.bus_oe, pin_out.upper_oe, 7'h0,
      pin_out.program_fetch_strobe_n});
  endtask
  task automatic t_program_pulse_input;
    int   n;
    int   rises;
    logic was;
    drv.mode_select = 1'b0;
    cyc(4);
    drv.efs_high_voltage = 1'b1;
    // programmer looks for the strobe clock before it programs
    rises = 0;
    was = pin_out.ale;
    for (n = 0; n < 40; n++) begin
      cyc(1);
      if (pin_out.ale && !was) rises++;
      was = pin_out.ale;
    end
    chk("strobe clock", 12'h002, rises[11:0]);
    write_word(10'h2c3, 8'hc9, PMIN + 6);
    chk("verify word", 12'h1c9, {3'h0, pin_out.bus_oe, pin_out.bus_out});
    write_word(10'h155, 8'h77, PMIN - 8);
    chk("short pulse", 12'h100, {3'h0, pin_out.bus_oe, pin_out.bus_out});
    drv.chip_reset_n = 1'b0;
    cyc(4);
    drv.efs_high_voltage = 1'b0;
    drv.external_fetch_select = 1'b1;
    cyc(4);
    drv.chip_reset_n = 1'b1;
  endtask
  task automatic t_fetch;
    int n;
    for (n = 0; n < 100 && core_rsp.instr_valid !== 1'b1; n++) cyc(1);
    bound(n, 100);
    chk("fetched byte", 12'h0b6, {4'h0, core_rsp.instr});
  endtask
  task automatic t_step;
    int n;
    core_req.insn_start = 1'b0;
    drv.step_request_n = 1'b0;
    cyc(60);
    chk("second cycle", 12'h000, {11'h0, core_rsp.halted});
    core_req.insn_start = 1'b1;
    for (n = 0; n < 60 && core_rsp.halted !== 1'b1; n++) cyc(1);
    bound(n, 60);
    cyc(30);
    chk("halt strobe", 12'h001, {11'h0, pin_out.ale});
    chk("halt addr", 12'h1a5, {pin_out.upper_port_address_lines, pin_out.bus_out});
    drv.step_request_n = 1'b1;
    for (n = 0; n < 20 && core_rsp.halted !== 1'b0; n++) cyc(1);
    bound(n, 20);
    chk("resume strobe", 12'h000, {11'h0, pin_out.ale});
    t_fetch();
  endtask
  // reset taken while halted, then an internal fetch with port data at the strobe rise
  task automatic t_int;
    int n;
    drv.step_request_n = 1'b0;
    for (n = 0; n < 60 && core_rsp.halted !== 1'b1; n++) cyc(1);
    bound(n, 60);
    drv.chip_reset_n = 1'b0;
    cyc(4);
    drv.step_request_n = 1'b1;
    drv.external_fetch_select = 1'b0;
    core_req.pc = 12'h2c3;
    core_req.io_bus = 8'h3c;
    core_req.io_bus_oe = 1'b1;
    core_req.io_upper = 4'h9;
    core_req.io_upper_oe = 1'b1;
    cyc(4);
    drv.chip_reset_n = 1'b1;
    for (n = 0; n < 60 && core_rsp.instr_valid !== 1'b1; n++) cyc(1);
    bound(n, 60);
    chk("internal byte", 12'h0c9, {4'h0, core_rsp.instr});
    for (n = 0; n < 40 && pin_out.ale !== 1'b1; n++) cyc(1);
    bound(n, 40);
    chk("port at strobe", 12'h93c, {pin_out.upper_port_address_lines, pin_out.bus_out});
    chk("port enables", 12'h003, {10'h0, pin_out.upper_oe, pin_out.bus_oe});
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    test_done();
  end
  initial begin
    rst_b = 1'b0;
    host_en = 1'b0;
    drv = '0;
    drv.mode_select = 1'b1;
    drv.step_request_n = 1'b1;
    core_req = '0;
    core_req.fetch = 1'b1;
    core_req.insn_start = 1'b1;
    core_req.pc = 12'h1a5;
    miscompares = 0;
    checks = 0;
    cyc(16);
    rst_b = 1'b1;
    cyc(4);
    t_reset();
    t_program_pulse_input();
    t_fetch();
    t_step();
    t_int();
    test_done();
  end
endmodule // test_pmv_port
